//--- rus_record_engine.sv
// Function
// - Update only with update permission
// - Failed update keeps pointer unchanged
// - Cyclic file accepts previous mode only
// - Current mode writes pointed record, pointer kept
// - Absolute mode writes given record, pointer kept
// - Next advances pointer; unset means first
// - Next at last linear record fails
// - Previous steps back; unset means last
// - Previous at first linear record fails
// - Cyclic update writes oldest, becomes record 1
// - Mode byte: file ref high, mode low
// - Search only with read permission
// - Simple search compares from byte one
// - Enhanced data: two-byte indication, then string
// - Offset mode compares from given position
// - Occurrence mode compares after first key byte
// - Search mode byte selects search kind
// - Indication low bits select start and direction
// - First byte 00 means current record
// - Return matching numbers, at most expected length
// - Match sets pointer to first match
// - No match gives 6282
`timescale 1ns/100ps
module rus_record_engine (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [9:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             busy_o,
  output logic             done_o
);
  localparam int RLEN_BITS = rus_pkg::RLEN * 8;
  logic [7:0]  mem [0:rus_pkg::NREC*rus_pkg::RLEN-1];
  logic [7:0]  dbuf [0:rus_pkg::DBUF-1];
  logic [7:0]  p1;
  logic [7:0]  p2;
  logic        op_search;
  logic        file_cyc;
  logic        perm_upd;
  logic        perm_rd;
  logic [3:0]  nrec;
  logic [5:0]  lc;
  logic [3:0]  le;
  logic [15:0] sw;
  logic [3:0]  res_cnt;
  logic [31:0] res_list;
  logic [3:0]  ptr;
  logic [2:0]  head;
  rus_pkg::rus_state_t st;
  logic [3:0]  cur_rec;
  logic        scan_bwd;
  logic        found;
  logic [4:0]  wr_idx;
  logic [2:0]  wr_phys;
  logic [3:0]  wr_ptr;
  logic [2:0]  wr_head;
  logic        go;
  logic        sw_wr;
  logic        dec_ok;
  logic [15:0] dec_sw;
  logic [3:0]  dec_rec;
  logic [3:0]  dec_ptr;
  logic [2:0]  dec_head;
  logic        dec_empty;
  logic        dec_bwd;
  logic [5:0]  plen;
  logic        enh;
  logic        occ;
  logic [2:0]  rsel;
  logic [RLEN_BITS-1:0] rec_flat;
  logic [RLEN_BITS-1:0] pat_flat;
  logic        hit;
  logic        scan_last;

  function automatic logic [2:0] to_phys(input logic [3:0] lrec, input logic [2:0] hd,
                                         input logic [3:0] n);
    logic [4:0] s;
    s = 5'(hd) + 5'(lrec) - 5'h01;
    if (s >= 5'(n)) s = s - 5'(n);
    return s[2:0];
  endfunction

  assign sw_wr = reg_wr_i && st == rus_pkg::ST_IDLE;
  assign go    = sw_wr && reg_addr_i == rus_pkg::OFF_CMD && reg_wdata_i[rus_pkg::CMD_GO_BIT];
  assign enh   = p2[2:0] == rus_pkg::SRCH_ENH;
  assign occ   = enh && dbuf[0][7:3] == rus_pkg::IND_OCCUR;
  assign rsel  = enh ? dbuf[0][2:0] : p2[2:0];

  // Command, file and length registers; only taken while idle
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p1        <= 8'h00;
      p2        <= 8'h00;
      op_search <= 1'b0;
      file_cyc  <= 1'b0;
      perm_upd  <= rus_pkg::UPD_RST;
      perm_rd   <= rus_pkg::RD_RST;
      nrec      <= rus_pkg::NREC_RST;
      lc        <= 6'h00;
      le        <= 4'h0;
    end else if (sw_wr) begin
      if (reg_addr_i == rus_pkg::OFF_CMD) begin
        p1        <= reg_wdata_i[rus_pkg::CMD_P1_LSB +: 8];
        p2        <= reg_wdata_i[rus_pkg::CMD_P2_LSB +: 8];
        op_search <= reg_wdata_i[rus_pkg::CMD_OP_BIT];
      end
      if (reg_addr_i == rus_pkg::OFF_FILE) begin
        file_cyc <= reg_wdata_i[rus_pkg::FILE_CYC_BIT];
        perm_upd <= reg_wdata_i[rus_pkg::FILE_UPD_BIT];
        perm_rd  <= reg_wdata_i[rus_pkg::FILE_RD_BIT];
        nrec     <= reg_wdata_i[rus_pkg::FILE_NREC_LSB +: 4];
      end
      if (reg_addr_i == rus_pkg::OFF_LEN) begin
        lc <= reg_wdata_i[rus_pkg::LEN_LC_LSB +: 6];
        le <= reg_wdata_i[rus_pkg::LEN_LE_LSB +: 4];
      end
    end
  end

  // Data buffer and record store; records are not reset, as in a real array
  always_ff @(posedge ref_clk_i) begin
    if (sw_wr && reg_addr_i[9:7] == rus_pkg::SEL_DBUF) begin
      dbuf[reg_addr_i[6:2]] <= reg_wdata_i[7:0];
    end
    if (sw_wr && reg_addr_i[9] == rus_pkg::SEL_MEM) begin
      mem[reg_addr_i[8:2]] <= reg_wdata_i[7:0];
    end else if (st == rus_pkg::ST_WRITE) begin
      mem[{wr_phys, wr_idx[3:0]}] <= dbuf[wr_idx];
    end
  end

  // Decision taken in the check cycle
  always_comb begin
    dec_ok    = 1'b0;
    dec_sw    = rus_pkg::SW_OK;
    dec_rec   = 4'h0;
    dec_ptr   = ptr;
    dec_head  = head;
    dec_empty = 1'b0;
    dec_bwd   = 1'b0;
    plen      = enh ? lc - 6'h02 : lc;
    if (!op_search) begin
      if (!perm_upd) begin
        dec_sw = rus_pkg::SW_NOPERM;
      end else if (p2[7:3] == rus_pkg::FREF_RSV ||
                   (p2[2:0] != rus_pkg::MODE_NEXT && p2[2:0] != rus_pkg::MODE_PREV &&
                    p2[2:0] != rus_pkg::MODE_ABS)) begin
        dec_sw = rus_pkg::SW_BADP;
      end else if (file_cyc && p2[2:0] != rus_pkg::MODE_PREV) begin
        dec_sw = rus_pkg::SW_STRUCT;
      end else if (lc != 6'(rus_pkg::RLEN)) begin
        dec_sw = rus_pkg::SW_BADLEN;
      end else if (file_cyc) begin
        dec_ok   = 1'b1;
        dec_rec  = nrec;
        dec_ptr  = 4'h1;
        dec_head = to_phys(nrec, head, nrec);
      end else begin
        case (p2[2:0])
          rus_pkg::MODE_NEXT: begin
            if (ptr == 4'h0) begin
              dec_ok  = 1'b1;
              dec_rec = 4'h1;
            end else if (ptr >= nrec) begin
              dec_sw = rus_pkg::SW_NOREC;
            end else begin
              dec_ok  = 1'b1;
              dec_rec = ptr + 4'h1;
            end
            dec_ptr = dec_rec;
          end
          rus_pkg::MODE_PREV: begin
            if (ptr == 4'h0) begin
              dec_ok  = 1'b1;
              dec_rec = nrec;
            end else if (ptr == 4'h1) begin
              dec_sw = rus_pkg::SW_NOREC;
            end else begin
              dec_ok  = 1'b1;
              dec_rec = ptr - 4'h1;
            end
            dec_ptr = dec_rec;
          end
          default: begin
            dec_rec = (p1 == 8'h00) ? ptr : p1[3:0];
            dec_ok  = (p1 == 8'h00) ? ptr != 4'h0 : p1 <= {4'h0, nrec};
            if (!dec_ok) dec_sw = rus_pkg::SW_NOREC;
          end
        endcase
      end
    end else begin
      case (rsel)
        rus_pkg::SRCH_FWD, rus_pkg::SRCH_BWD: dec_rec = (p1 == 8'h00) ? ptr : p1[3:0];
        rus_pkg::IND_FWD_NEXT: dec_rec = (ptr == 4'h0) ? 4'h1 : ptr + 4'h1;
        default: dec_rec = (ptr == 4'h0) ? nrec : ptr - 4'h1;
      endcase
      if (p2[2:0] == rus_pkg::SRCH_PROP) dec_rec = 4'h1;
      dec_bwd   = p2[2:0] != rus_pkg::SRCH_PROP && rsel[0];
      dec_empty = dec_rec == 4'h0 || dec_rec > nrec || (p1 > {4'h0, nrec});
      if (!perm_rd) begin
        dec_sw = rus_pkg::SW_NOPERM;
      end else if (p2[7:3] == rus_pkg::FREF_RSV || !p2[2]) begin
        dec_sw = rus_pkg::SW_BADP;
      end else if (enh && (!dbuf[0][2] || (dbuf[0][7:3] != rus_pkg::IND_OFFSET &&
                                           dbuf[0][7:3] != rus_pkg::IND_OCCUR))) begin
        dec_sw = rus_pkg::SW_BADP;
      end else if ((enh && lc < 6'h03) || lc == 6'h00 || plen > 6'(rus_pkg::RLEN)) begin
        dec_sw = rus_pkg::SW_BADLEN;
      end else begin
        dec_ok = 1'b1;
      end
    end
  end

  // Record under scan and the pattern, pattern after the indication in enhanced mode
  always_comb begin
    rec_flat = '0;
    pat_flat = '0;
    for (int i = 0; i < rus_pkg::RLEN; i++) begin
      rec_flat[i*8 +: 8] = mem[{to_phys(cur_rec, head, nrec), 4'(i)}];
      pat_flat[i*8 +: 8] = dbuf[enh ? i + 2 : i];
    end
  end

  rus_rec_match u_match (
    .rec_i (rec_flat),
    .pat_i (pat_flat),
    .len_i (plen),
    .occ_i (occ),
    .key_i (dbuf[1]),
    .off_i (enh ? dbuf[1] : 8'h00),
    .hit_o (hit)
  );

  assign scan_last = scan_bwd ? cur_rec == 4'h1 : cur_rec >= nrec;

  // Sequencer, status word and result list
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st       <= rus_pkg::ST_IDLE;
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      sw       <= rus_pkg::SW_OK;
      res_cnt  <= 4'h0;
      res_list <= 32'h0000_0000;
      cur_rec  <= 4'h0;
      scan_bwd <= 1'b0;
      found    <= 1'b0;
      wr_idx   <= 5'h00;
      wr_phys  <= 3'h0;
      wr_ptr   <= 4'h0;
      wr_head  <= 3'h0;
    end else begin
      done_o <= 1'b0;
      case (st)
        rus_pkg::ST_IDLE: begin
          if (go) begin
            st       <= rus_pkg::ST_CHECK;
            busy_o   <= 1'b1;
            res_cnt  <= 4'h0;
            res_list <= 32'h0000_0000;
            found    <= 1'b0;
          end
        end
        rus_pkg::ST_CHECK: begin
          cur_rec  <= dec_rec;
          scan_bwd <= dec_bwd;
          wr_idx   <= 5'h00;
          wr_phys  <= to_phys(dec_rec, head, nrec);
          wr_ptr   <= dec_ptr;
          wr_head  <= dec_head;
          if (!dec_ok) begin
            st     <= rus_pkg::ST_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            sw     <= dec_sw;
          end else if (op_search && dec_empty) begin
            st     <= rus_pkg::ST_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            sw     <= rus_pkg::SW_NOMATCH;
          end else begin
            st <= op_search ? rus_pkg::ST_SCAN : rus_pkg::ST_WRITE;
          end
        end
        rus_pkg::ST_SCAN: begin
          if (hit) begin
            found <= 1'b1;
            // Numbers beyond the expected length are dropped, not counted
            if (res_cnt < le && res_cnt < 4'(rus_pkg::NREC)) begin
              res_list[res_cnt*4 +: 4] <= cur_rec;
              res_cnt                  <= res_cnt + 4'h1;
            end
          end
          if (scan_last) begin
            st     <= rus_pkg::ST_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            sw     <= (found || hit) ? rus_pkg::SW_OK : rus_pkg::SW_NOMATCH;
          end else begin
            cur_rec <= scan_bwd ? cur_rec - 4'h1 : cur_rec + 4'h1;
          end
        end
        rus_pkg::ST_WRITE: begin
          wr_idx <= wr_idx + 5'h01;
          if (wr_idx == 5'(rus_pkg::RLEN - 1)) begin
            st     <= rus_pkg::ST_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            sw     <= rus_pkg::SW_OK;
          end
        end
        default: begin
          st     <= rus_pkg::ST_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // Pointer and cyclic head; a file write clears both, a finished update loads both from the decision, a first match moves the pointer
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr  <= 4'h0;
      head <= 3'h0;
    end else if (sw_wr && reg_addr_i == rus_pkg::OFF_FILE) begin
      ptr  <= 4'h0;
      head <= 3'h0;
    end else if (st == rus_pkg::ST_WRITE && wr_idx == 5'(rus_pkg::RLEN - 1)) begin
      ptr  <= wr_ptr;
      head <= wr_head;
    end else if (st == rus_pkg::ST_SCAN && hit && !found) begin
      ptr <= cur_rec;
    end
  end

  // Read port, data in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_addr_i == rus_pkg::OFF_CMD) begin
        reg_rdata_o[rus_pkg::CMD_P1_LSB +: 8] <= p1;
        reg_rdata_o[rus_pkg::CMD_P2_LSB +: 8] <= p2;
        reg_rdata_o[rus_pkg::CMD_OP_BIT]      <= op_search;
      end else if (reg_addr_i == rus_pkg::OFF_FILE) begin
        reg_rdata_o[rus_pkg::FILE_CYC_BIT]         <= file_cyc;
        reg_rdata_o[rus_pkg::FILE_UPD_BIT]         <= perm_upd;
        reg_rdata_o[rus_pkg::FILE_RD_BIT]          <= perm_rd;
        reg_rdata_o[rus_pkg::FILE_NREC_LSB +: 4]   <= nrec;
      end else if (reg_addr_i == rus_pkg::OFF_LEN) begin
        reg_rdata_o[rus_pkg::LEN_LC_LSB +: 6] <= lc;
        reg_rdata_o[rus_pkg::LEN_LE_LSB +: 4] <= le;
      end else if (reg_addr_i == rus_pkg::OFF_STAT) begin
        reg_rdata_o[rus_pkg::STAT_BUSY_BIT]     <= busy_o;
        reg_rdata_o[rus_pkg::STAT_CNT_LSB +: 4] <= res_cnt;
        reg_rdata_o[rus_pkg::STAT_SW_LSB +: 16] <= sw;
      end else if (reg_addr_i == rus_pkg::OFF_PTR) begin
        reg_rdata_o[3:0] <= ptr;
      end else if (reg_addr_i == rus_pkg::OFF_RES) begin
        reg_rdata_o <= res_list;
      end else if (reg_addr_i[9:7] == rus_pkg::SEL_DBUF) begin
        reg_rdata_o[7:0] <= dbuf[reg_addr_i[6:2]];
      end else if (reg_addr_i[9] == rus_pkg::SEL_MEM) begin
        reg_rdata_o[7:0] <= mem[reg_addr_i[8:2]];
      end
    end
  end

endmodule // rus_record_engine

//--- rus_pkg.sv
package rus_pkg;

  localparam int NREC = 8;
  localparam int RLEN = 16;
  localparam int DBUF = 32;

  localparam logic [9:0] OFF_CMD  = 10'h000;
  localparam logic [9:0] OFF_FILE = 10'h004;
  localparam logic [9:0] OFF_LEN  = 10'h008;
  localparam logic [9:0] OFF_STAT = 10'h00c;
  localparam logic [9:0] OFF_PTR  = 10'h010;
  localparam logic [9:0] OFF_RES  = 10'h014;
  localparam logic [2:0] SEL_DBUF = 3'h1;
  localparam logic       SEL_MEM  = 1'h1;

  localparam int CMD_P1_LSB    = 0;
  localparam int CMD_P2_LSB    = 8;
  localparam int CMD_OP_BIT    = 16;
  localparam int CMD_GO_BIT    = 31;
  localparam int FILE_CYC_BIT  = 0;
  localparam int FILE_UPD_BIT  = 1;
  localparam int FILE_RD_BIT   = 2;
  localparam int FILE_NREC_LSB = 4;
  localparam int LEN_LC_LSB    = 0;
  localparam int LEN_LE_LSB    = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CNT_LSB  = 8;
  localparam int STAT_SW_LSB   = 16;

  localparam logic [3:0] NREC_RST = 4'h8;
  localparam logic       UPD_RST  = 1'h1;
  localparam logic       RD_RST   = 1'h1;

  localparam logic [2:0] MODE_NEXT    = 3'h2;
  localparam logic [2:0] MODE_PREV    = 3'h3;
  localparam logic [2:0] MODE_ABS     = 3'h4;
  localparam logic [2:0] SRCH_FWD     = 3'h4;
  localparam logic [2:0] SRCH_BWD     = 3'h5;
  localparam logic [2:0] SRCH_ENH     = 3'h6;
  localparam logic [2:0] SRCH_PROP    = 3'h7;
  localparam logic [2:0] IND_FWD_NEXT = 3'h6;
  localparam logic [2:0] IND_BWD_PREV = 3'h7;
  localparam logic [4:0] IND_OFFSET   = 5'h00;
  localparam logic [4:0] IND_OCCUR    = 5'h01;
  localparam logic [4:0] FREF_RSV     = 5'h1f;

  localparam logic [15:0] SW_OK      = 16'h9000;
  localparam logic [15:0] SW_NOMATCH = 16'h6282;
  localparam logic [15:0] SW_NOPERM  = 16'h6982;
  localparam logic [15:0] SW_STRUCT  = 16'h6981;
  localparam logic [15:0] SW_BADP    = 16'h6a86;
  localparam logic [15:0] SW_NOREC   = 16'h6a83;
  localparam logic [15:0] SW_BADLEN  = 16'h6700;

  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_SCAN, ST_WRITE} rus_state_t;

endpackage

//--- rus_rec_match.sv
`timescale 1ns/100ps
module rus_rec_match (
  input  wire logic [rus_pkg::RLEN*8-1:0] rec_i,
  input  wire logic [rus_pkg::RLEN*8-1:0] pat_i,
  input  wire logic [5:0]                 len_i,
  input  wire logic                       occ_i,
  input  wire logic [7:0]                 key_i,
  input  wire logic [7:0]                 off_i,
  output logic                            hit_o
);
  int start;

  always_comb begin
    start = int'(off_i);
    hit_o = 1'b1;
    if (occ_i) begin
      // Lowest matching byte wins; no key byte means no match
      start = rus_pkg::RLEN + 1;
      for (int i = rus_pkg::RLEN - 1; i >= 0; i--) begin
        if (rec_i[i*8 +: 8] == key_i) begin
          start = i + 1;
        end
      end
    end
    if (len_i == 6'h00 || start + int'(len_i) > rus_pkg::RLEN) begin
      hit_o = 1'b0;
    end
    for (int i = 0; i < rus_pkg::RLEN; i++) begin
      if (i < int'(len_i) && start + i < rus_pkg::RLEN) begin
        if (rec_i[(start+i)*8 +: 8] != pat_i[i*8 +: 8]) begin
          hit_o = 1'b0;
        end
      end
    end
  end
endmodule // rus_rec_match

//--- rus_term_model.sv
`timescale 1ns/100ps
// Terminal side: one access at a time, strobes one cycle long
module rus_term_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        done_i,
  output logic      [9:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o = 10'h000;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Stale data would hide a missed strobe
    wdata_o <= ~v;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    v = rdata_i;
  endtask
  task automatic go(input logic [7:0] p1, input logic [7:0] p2, input logic op);
    logic [7:0] q;
    q = (!op && p2[2:1] == 2'h1) ? 8'h00 : p1;
    wr(rus_pkg::OFF_CMD, {1'b1, 14'h0, op, p2, q});
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #1;
      if (done_i) break;
    end
  endtask
endmodule // rus_term_model

//--- rus_record_engine_asserts.sv
`timescale 1ns/100ps
module rus_record_engine_asserts (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [9:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        busy_o,
  input wire logic        done_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic       go;
  logic       upd_go;
  logic       srch_go;
  logic [2:0] mode;
  assign go = reg_wr_i && reg_addr_i == rus_pkg::OFF_CMD && reg_wdata_i[31] && !busy_o;
  assign upd_go = go && !reg_wdata_i[16];
  assign srch_go = go && reg_wdata_i[16];
  assign mode = reg_wdata_i[10:8];
  chk_go_busy: assert property (go |=> busy_o && !done_o)
    else $error("command did not start");
  chk_fref_rsv: assert property (go && reg_wdata_i[15:11] == 5'h1f |-> ##2 done_o)
    else $error("reserved file ref not refused");
  chk_upd_mode: assert property (upd_go && (mode < 3'h2 || mode > 3'h4) |-> ##2 done_o)
    else $error("reserved update mode not refused");
  chk_srch_rsv: assert property (srch_go && !mode[2] |-> ##2 done_o)
    else $error("reserved search mode not refused");
  chk_done_one: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  chk_done_end: assert property (done_o |-> !busy_o && $past(busy_o))
    else $error("done without a running command");
  chk_bounded: assert property ($rose(busy_o) |-> ##[1:24] !busy_o)
    else $error("command did not finish");
  chk_rd_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  chk_rd_zero: assert property (reg_rd_i && reg_addr_i == 10'h018 |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_ptr_rng: assert property (reg_rd_i && reg_addr_i == rus_pkg::OFF_PTR |=>
    reg_rdata_o <= 32'h8)
    else $error("pointer out of range");
  chk_stat_rd: assert property (reg_rd_i && reg_addr_i == rus_pkg::OFF_STAT |=>
    reg_rdata_o[11:8] <= 4'h8 && reg_rdata_o[0] == $past(busy_o))
    else $error("status count or busy wrong");
endmodule // rus_record_engine_asserts
bind rus_record_engine rus_record_engine_asserts chk_i (
  .ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .busy_o, .done_o
);

//--- record_update_search_engine_tb_top.sv
`timescale 1ns/100ps
module record_update_search_engine_tb_top;
  logic        clk, rstn, wr, rd, busy, done;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata, d;
  int          mem[8][16];
  int          n, ptr, head, cyc, up, rdp, n_fail, compares;
  rus_record_engine dut (.ref_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .busy_o(busy), .done_o(done));
  rus_term_model term (.clk_i(clk), .rdata_i(rdata), .done_i(done), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic setf(input int c, input int u, input int r, input int k);
    term.wr(rus_pkg::OFF_FILE, {24'h0, 4'(k), 1'b0, 1'(r), 1'(u), 1'(c)});
    cyc = c;
    up = u;
    rdp = r;
    n = k;
    ptr = 0;
    head = 0;
  endtask
  task automatic chk_st(input int sw);
    term.rd(rus_pkg::OFF_STAT, d);
    chk(32'(d[31:16]), sw);
    chk(32'(d[0]), 32'h0);
    term.rd(rus_pkg::OFF_PTR, d);
    chk(d, ptr);
  endtask
  task automatic upd(input int p1, input int p2);
    int b[16];
    int m, t, sw;
    m = p2 % 8;
    t = 0;
    sw = 'h9000;
    for (int i = 0; i < 16; i++) begin
      b[i] = $urandom % 256;
      term.wr(10'(128 + 4 * i), 32'(b[i]));
    end
    term.wr(rus_pkg::OFF_LEN, 32'h10);
    if (!up) sw = 'h6982;
    else if (p2 / 8 == 31 || m < 2 || m > 4) sw = 'h6a86;
    else if (cyc && m != 3) sw = 'h6981;
    else if (cyc) t = 1;
    else if (m == 2) t = ptr == 0 ? 1 : ptr + 1;
    else if (m == 3) t = ptr == 0 ? n : ptr - 1;
    else t = p1 == 0 ? ptr : p1;
    if (sw == 'h9000 && (t < 1 || t > n)) sw = 'h6a83;
    if (sw == 'h9000) begin
      if (cyc) head = (head + n - 1) % n;
      if (m != 4) ptr = t;
      for (int i = 0; i < 16; i++) mem[(head + t - 1) % n][i] = b[i];
    end
    term.go(8'(p1), 8'(p2), 1'b0);
    chk_st(sw);
  endtask
  task automatic srch(input int p1, input int p2, input int le, input int q[$]);
    int res[$];
    int m, dir, st, md, po, len, off, s, ok, sw;
    m = p2 % 8;
    dir = m == 5;
    st = p1 == 0 ? ptr : p1;
    md = 0;
    po = 0;
    off = 0;
    sw = 'h9000;
    for (int i = 0; i < q.size(); i++) term.wr(10'(128 + 4 * i), 32'(q[i]));
    term.wr(rus_pkg::OFF_LEN, 32'(le * 256 + q.size()));
    if (m == 7) st = 1;
    if (m == 6) begin
      md = q[0] / 8 + 1;
      dir = q[0] % 2;
      off = q[1];
      po = 2;
      // Unset pointer: next starts at the first record, previous at the last
      if (q[0] % 8 >= 6) st = ptr == 0 ? (dir ? n : 1) : ptr + (dir ? -1 : 1);
      if (md > 2 || q[0] % 8 < 4) sw = 'h6a86;
    end
    if (!rdp) sw = 'h6982;
    else if (p2 / 8 == 31 || m < 4) sw = 'h6a86;
    len = q.size() - po;
    if (sw == 'h9000) begin
      for (int r = st; r >= 1 && r <= n; r += dir ? -1 : 1) begin
        s = md == 1 ? off : md == 2 ? 99 : 0;
        for (int i = 15; md == 2 && i >= 0; i--) if (mem[r - 1][i] == off) s = i + 1;
        ok = s + len <= 16;
        for (int i = 0; i < len && ok; i++) ok = mem[r - 1][s + i] == q[po + i];
        if (ok) res.push_back(r);
      end
      if (res.size() == 0) sw = 'h6282;
      else ptr = res[0];
    end
    while (res.size() > le) void'(res.pop_back());
    term.go(8'(p1), 8'(p2), 1'b1);
    chk_st(sw);
    term.rd(rus_pkg::OFF_STAT, d);
    chk(32'(d[11:8]), res.size());
    // Results only fetched after a match
    if (sw == 'h9000) begin
      term.rd(rus_pkg::OFF_RES, d);
      for (int i = 0; i < res.size(); i++) chk(32'(d[4 * i +: 4]), res[i]);
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    test_done;
  end
  initial begin
    rstn = 1'b0;
    void'($urandom(37149));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    term.rd(rus_pkg::OFF_PTR, d);
    chk(d, 32'h0);
    term.rd(10'h018, d);
    chk(d, 32'h0);
    for (int p = 0; p < 8; p++) begin
      for (int b = 0; b < 16; b++) begin
        mem[p][b] = $urandom % 256;
        term.wr(10'(512 + 64 * p + 4 * b), 32'(mem[p][b]));
      end
    end
    setf(0, 1, 1, 8);
    upd(0, 2);
    upd(0, 2);
    upd(0, 4);
    upd(5, 4);
    term.wr(rus_pkg::OFF_LEN, 32'h0f);
    term.go(8'h05, 8'h04, 1'b0);
    chk_st('h6700);
    upd(0, 3);
    upd(9, 4);
    upd(0, 1);
    upd(0, 'hfa);
    upd(0, 'h0a);
    setf(0, 1, 1, 2);
    upd(0, 4);
    upd(0, 3);
    upd(0, 2);
    upd(0, 3);
    upd(0, 3);
    setf(0, 0, 1, 8);
    upd(1, 4);
    setf(1, 1, 1, 8);
    upd(0, 2);
    upd(2, 4);
    upd(0, 3);
    upd(0, 3);
    for (int p = 0; p < 8; p++) begin
      for (int b = 0; b < 16; b++) begin
        term.rd(10'(512 + 64 * p + 4 * b), d);
        chk(32'(d[7:0]), mem[p][b]);
      end
    end
    setf(0, 1, 1, 8);
    for (int r = 1; r < 8; r += 3) begin
      mem[r][0] = 'h5a;
      term.wr(10'(512 + 64 * r), 32'h5a);
    end
    srch(1, 4, 2, '{'h5a});
    srch(8, 5, 8, '{'h5a});
    srch(1, 4, 0, '{'h5a});
    srch(3, 6, 4, '{'h04, 6, mem[2][6], mem[2][7]});
    srch(1, 6, 4, '{'h0c, mem[4][0], mem[4][1], mem[4][2]});
    srch(0, 6, 4, '{'h06, 0, mem[6][0]});
    srch(0, 6, 4, '{'h07, 0, mem[1][0]});
    srch(1, 6, 4, '{'h10, 0, 'h5a});
    srch(8, 6, 4, '{'h05, 0, 'h5a});
    srch(0, 4, 4, '{'h5a});
    srch(1, 7, 4, '{'h5a});
    srch(1, 0, 4, '{'h5a});
    srch(1, 'hfc, 4, '{'h5a});
    srch(9, 4, 4, '{'h5a});
    srch(1, 4, 4, '{$urandom % 256, $urandom % 256, $urandom % 256});
    setf(0, 1, 1, 8);
    srch(0, 6, 4, '{'h07, 0, 'h5a});
    setf(0, 1, 0, 8);
    srch(1, 4, 4, '{'h5a});
    test_done;
  end
endmodule // record_update_search_engine_tb_top
